// *** wdi_dev.sv ***
// Purpose: Two-wire target giving access to the watchdog registers
// Assumes: scl and sda sampled synchronously to pclk, many pclk per bit
// Notes:   Pointer wraps from index 0x1f to 0x00
// Function
// RULE_01 - Answer own 7-bit address, default zero
// RULE_02 - Address is fixed constant, at most 1111110
// RULE_03 - Host opens write with address, direction 0
// RULE_04 - Second byte: low five bits select register
// RULE_05 - Acknowledge each received byte on ninth pulse
// RULE_06 - Third byte stored in addressed register
// RULE_07 - Further write bytes go to next index
// RULE_08 - Pointer wraps around after last index
// RULE_09 - Host ends writes with STOP or START
// RULE_10 - Read starts by writing index, then restart
// RULE_11 - Host resends address with direction bit 1
// RULE_12 - Send addressed register, MSB first, eight clocks
// RULE_13 - Host nacks single read then stops
// RULE_14 - Host ack means send next index
// RULE_15 - Host ends burst read with nack
// RULE_16 - All registers reachable through this port
// RULE_17 - Config writable only while key holds 0x5a
// RULE_18 - Timeout field selects period 80 to 1000 ms; code table spans 80 to 4000 ms
// RULE_19 - No general call, START byte, high speed
// RULE_20 - Enable field 01 disables watchdog
// RULE_21 - Reserved indices read zero, ignore writes
`timescale 1ns/1ns
`default_nettype none
module wdi_dev
    import wdi_pkg::*;
#(
    parameter logic [6:0] TARGET_ADDR = wdi_pkg::TARGET_ADDR_DEF
)(
    input  wire logic        pclk,
    input  wire logic        presetn,
    wdi_if.dev               link,
    output logic             watchdog_enable,
    output logic [11:0]      timeout_period_ms,
    output logic             config_access_open,
    output logic [7:0]       watchdog_config
);
    import wdi_pkg::*;

    typedef enum logic [2:0] {
        DV_IDLE,
        DV_ADDR,
        DV_INDEX,
        DV_WDATA,
        DV_RDATA
    } wdi_dst_t;

    // An out-of-range factory address never matches
    localparam logic ADDR_OK = (TARGET_ADDR <= TARGET_ADDR_MAX); // RULE_02

    wdi_dst_t    st_r,      st_nxt;
    logic        scl_p_r,   scl_p_nxt;
    logic        sda_p_r,   sda_p_nxt;
    logic [3:0]  cnt_r,     cnt_nxt;
    logic [7:0]  sh_r,      sh_nxt;
    logic [4:0]  ptr_r,     ptr_nxt;
    logic        rw_r,      rw_nxt;
    logic        nack_r,    nack_nxt;
    logic        oe_r,      oe_nxt;
    logic [7:0]  key_r,     key_nxt;
    logic [7:0]  cfg_r,     cfg_nxt;
    logic        wden_r,    wden_nxt;
    logic [11:0] tmo_r,     tmo_nxt;
    logic        open_r,    open_nxt;
    logic        rise;
    logic        fall;
    logic        start_ev;
    logic        stop_ev;
    logic [7:0]  rd_byte;

    function automatic logic [7:0] reg_read(
        input logic [4:0] idx,
        input logic [7:0] key,
        input logic [7:0] cfg
    );
        logic [7:0] v;
        v = 8'h00; // RULE_21
        if (idx == IDX_KEY)
            v = key;
        else if (idx == IDX_CFG)
            v = cfg;
        return v;
    endfunction : reg_read

    function automatic logic [11:0] tmo_ms(input logic [2:0] code);
        logic [11:0] ms;
        ms = TMO_MS_0;
        unique case (code)
            3'h0: ms = TMO_MS_0;
            3'h1: ms = TMO_MS_1;
            3'h2: ms = TMO_MS_2;
            3'h3: ms = TMO_MS_3;
            3'h4: ms = TMO_MS_4;
            3'h5: ms = TMO_MS_5;
            3'h6: ms = TMO_MS_6;
            3'h7: ms = TMO_MS_7;
        endcase
        return ms;
    endfunction : tmo_ms

    always_comb
    begin
        st_nxt    = st_r;
        cnt_nxt   = cnt_r;
        sh_nxt    = sh_r;
        ptr_nxt   = ptr_r;
        rw_nxt    = rw_r;
        nack_nxt  = nack_r;
        oe_nxt    = oe_r;
        key_nxt   = key_r;
        cfg_nxt   = cfg_r;
        rd_byte   = 8'h00;
        scl_p_nxt = link.scl;
        sda_p_nxt = link.sda;
        rise      = link.scl & ~scl_p_r;
        fall      = ~link.scl & scl_p_r;
        start_ev  = link.scl & scl_p_r & sda_p_r & ~link.sda;
        stop_ev   = link.scl & scl_p_r & ~sda_p_r & link.sda;

        if (stop_ev)
        begin
            st_nxt = DV_IDLE;
            oe_nxt = 1'b0;
        end
        else if (start_ev)
        begin
            // Repeated start also lands here and keeps the pointer
            st_nxt  = DV_ADDR;
            cnt_nxt = 4'h0;
            oe_nxt  = 1'b0;
        end
        else if (st_r != DV_IDLE)
        begin
            if (rise)
            begin
                if (cnt_r < 4'h9)
                    cnt_nxt = cnt_r + 4'h1;
                if (cnt_r < 4'h8 && st_r != DV_RDATA)
                    sh_nxt = {sh_r[6:0], link.sda}; // RULE_04
                if (cnt_r == 4'h8 && st_r == DV_RDATA)
                    nack_nxt = link.sda; // RULE_14
            end
            else if (fall)
            begin
                if (cnt_r == 4'h8)
                begin
                    unique case (st_r)
                        DV_ADDR:
                        begin
                            // General call and START byte get no
                            // special meaning; only the own address
                            if (ADDR_OK && sh_r[7:1] == TARGET_ADDR) // RULE_01 RULE_19
                            begin
                                oe_nxt = 1'b1; // RULE_05
                                rw_nxt = sh_r[0];
                            end
                            else
                                st_nxt = DV_IDLE;
                        end
                        DV_INDEX:
                        begin
                            ptr_nxt = sh_r[4:0]; // RULE_04
                            oe_nxt  = 1'b1; // RULE_05
                        end
                        DV_WDATA:
                        begin
                            if (ptr_r == IDX_KEY)
                                key_nxt = sh_r; // RULE_06 RULE_16
                            else if (ptr_r == IDX_CFG && key_r == KEY_OPEN)
                                cfg_nxt = sh_r; // RULE_17
                            ptr_nxt = ptr_r + 5'h01; // RULE_07 RULE_08
                            oe_nxt  = 1'b1; // RULE_05
                        end
                        DV_RDATA:
                            oe_nxt = 1'b0;
                        default:
                            oe_nxt = 1'b0;
                    endcase
                end
                else if (cnt_r == 4'h9)
                begin
                    cnt_nxt = 4'h0;
                    oe_nxt  = 1'b0;
                    unique case (st_r)
                        DV_ADDR:
                        begin
                            if (rw_r)
                            begin
                                rd_byte = reg_read(ptr_r, key_r, cfg_r);
                                st_nxt  = DV_RDATA;
                                sh_nxt  = rd_byte;
                                oe_nxt  = ~rd_byte[7]; // RULE_12
                            end
                            else
                                st_nxt = DV_INDEX;
                        end
                        DV_INDEX:
                            st_nxt = DV_WDATA;
                        DV_WDATA:
                            st_nxt = DV_WDATA;
                        DV_RDATA:
                        begin
                            if (nack_r)
                                st_nxt = DV_IDLE; // RULE_13 RULE_15
                            else
                            begin
                                ptr_nxt = ptr_r + 5'h01; // RULE_14 RULE_08
                                rd_byte = reg_read(ptr_nxt, key_r, cfg_r);
                                sh_nxt  = rd_byte;
                                oe_nxt  = ~rd_byte[7];
                            end
                        end
                        default:
                            st_nxt = DV_IDLE;
                    endcase
                end
                else if (st_r == DV_RDATA && cnt_r != 4'h0)
                begin
                    sh_nxt = {sh_r[6:0], 1'b0};
                    oe_nxt = ~sh_r[6]; // RULE_12
                end
            end
        end

        wden_nxt = (cfg_nxt[CFG_EN_MSB:CFG_EN_LSB] != CFG_EN_OFF); // RULE_20
        tmo_nxt  = tmo_ms(cfg_nxt[CFG_TMO_MSB:CFG_TMO_LSB]); // RULE_18
        open_nxt = (key_nxt == KEY_OPEN);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r    <= DV_IDLE;
            scl_p_r <= 1'b1;
            sda_p_r <= 1'b1;
            cnt_r   <= 4'h0;
            sh_r    <= 8'h00;
            ptr_r   <= 5'h00;
            rw_r    <= 1'b0;
            nack_r  <= 1'b0;
            oe_r    <= 1'b0;
            key_r   <= KEY_RST;
            cfg_r   <= CFG_RST;
            wden_r  <= 1'b1;
            tmo_r   <= TMO_MS_1;
            open_r  <= 1'b0;
        end
        else
        begin
            st_r    <= st_nxt;
            scl_p_r <= scl_p_nxt;
            sda_p_r <= sda_p_nxt;
            cnt_r   <= cnt_nxt;
            sh_r    <= sh_nxt;
            ptr_r   <= ptr_nxt;
            rw_r    <= rw_nxt;
            nack_r  <= nack_nxt;
            oe_r    <= oe_nxt;
            key_r   <= key_nxt;
            cfg_r   <= cfg_nxt;
            wden_r  <= wden_nxt;
            tmo_r   <= tmo_nxt;
            open_r  <= open_nxt;
        end
    end

    // Open drain: the line is only ever pulled low
    assign link.dev_sda_o    = 1'b0;
    assign link.dev_sda_oe   = oe_r;
    assign watchdog_enable   = wden_r;
    assign timeout_period_ms = tmo_r;
    assign config_access_open = open_r;
    assign watchdog_config   = cfg_r;
endmodule : wdi_dev
`default_nettype wire

// *** wdi_pkg.sv ***
// Purpose: Shared constants for the two-wire watchdog register port
// Assumes: 20 MHz pclk, register space indexed by 5 bits
// Notes:   Host command map is reached over APB
package wdi_pkg;
    localparam logic [6:0] TARGET_ADDR_DEF = 7'h00;
    localparam logic [6:0] TARGET_ADDR_MAX = 7'h7e;
    localparam int         IDX_W           = 5;
    localparam logic [4:0] IDX_KEY         = 5'h02;
    localparam logic [4:0] IDX_CFG         = 5'h03;
    localparam logic [7:0] KEY_OPEN        = 8'h5a;
    localparam logic [7:0] KEY_RST         = 8'h00;
    localparam logic [7:0] CFG_RST         = 8'h09;
    localparam int         CFG_EN_MSB      = 7;
    localparam int         CFG_EN_LSB      = 6;
    localparam logic [1:0] CFG_EN_OFF      = 2'h1;
    localparam int         CFG_TMO_MSB     = 5;
    localparam int         CFG_TMO_LSB     = 3;
    localparam logic [11:0] TMO_MS_0       = 12'h050;
    localparam logic [11:0] TMO_MS_1       = 12'h0a0;
    localparam logic [11:0] TMO_MS_2       = 12'h140;
    localparam logic [11:0] TMO_MS_3       = 12'h1e0;
    localparam logic [11:0] TMO_MS_4       = 12'h320;
    localparam logic [11:0] TMO_MS_5       = 12'h3e8;
    localparam logic [11:0] TMO_MS_6       = 12'h7d0;
    localparam logic [11:0] TMO_MS_7       = 12'hfa0;
    localparam int         PCLK_NS         = 50;
    localparam int         SCL_PERIOD_NS   = 10000;
    localparam int         QUARTER_CYC     = SCL_PERIOD_NS / (4 * PCLK_NS);
    localparam logic [7:0] HC_CMD          = 8'h00;
    localparam logic [7:0] HC_TXD          = 8'h04;
    localparam logic [7:0] HC_STAT         = 8'h08;
    localparam logic [7:0] HC_DIV          = 8'h0c;
    localparam int         CMD_OP_LSB      = 0;
    localparam int         CMD_ACK_BIT     = 2;
    localparam int         STAT_BUSY       = 0;
    localparam int         STAT_NACK       = 1;
    localparam int         STAT_RXD_LSB    = 8;
    typedef enum logic [1:0] {
        OP_START,
        OP_WRITE,
        OP_READ,
        OP_STOP
    } wdi_op_t;
endpackage : wdi_pkg

// *** wdi_if.sv ***
// Purpose: Two-wire link between controller and target
// Assumes: Only the controller drives the clock line
// Notes:   Data line is open drain; enable high pulls it low
`timescale 1ns/1ns
`default_nettype none
interface wdi_if;
    logic scl;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic sda;

    // Wired-AND with a pull-up when nobody drives
    assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

    modport host (
        output scl,
        output host_sda_o,
        output host_sda_oe,
        input  sda
    );
    modport dev (
        input  scl,
        input  sda,
        output dev_sda_o,
        output dev_sda_oe
    );
endinterface : wdi_if
`default_nettype wire

// *** wdi_host.sv ***
// Purpose: Two-wire controller driven by byte commands over APB
// Assumes: Target never stretches the clock
// Notes:   Commands written while busy are dropped
`timescale 1ns/1ns
`default_nettype none
module wdi_host
    import wdi_pkg::*;
#(
    parameter logic [15:0] QUARTER = 16'(wdi_pkg::QUARTER_CYC)
)(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    wdi_if.host              link
);
    import wdi_pkg::*;

    typedef enum logic [1:0] {
        EH_IDLE,
        EH_START,
        EH_BIT,
        EH_STOP
    } wdi_hst_t;

    logic [31:0] prdata_r,  prdata_nxt;
    logic        pready_r,  pready_nxt;
    logic        perr_r,    perr_nxt;
    logic [7:0]  txd_r,     txd_nxt;
    logic [15:0] div_r,     div_nxt;
    wdi_hst_t    st_r,      st_nxt;
    logic [1:0]  q_r,       q_nxt;
    logic [3:0]  bit_r,     bit_nxt;
    logic [15:0] dcnt_r,    dcnt_nxt;
    logic [7:0]  sh_r,      sh_nxt;
    logic        rd_r,      rd_nxt;
    logic        ackv_r,    ackv_nxt;
    logic        nack_r,    nack_nxt;
    logic        scl_r,     scl_nxt;
    logic        rel_r,     rel_nxt;
    logic        done;
    logic        mapped;
    logic        cmd_go;
    logic        tick;
    wdi_op_t     op;

    assign done   = psel & penable & pready_r;
    assign mapped = (paddr == HC_CMD) | (paddr == HC_TXD) |
                    (paddr == HC_STAT) | (paddr == HC_DIV);
    assign cmd_go = done & pwrite & (paddr == HC_CMD) & (st_r == EH_IDLE);
    assign op     = wdi_op_t'(pwdata[CMD_OP_LSB +: 2]);

    // Zero-wait slave; read data is captured in the setup cycle
    always_comb
    begin
        prdata_nxt = prdata_r;
        pready_nxt = psel & ~penable & ~pready_r;
        perr_nxt   = psel & ~penable & ~mapped;
        txd_nxt    = txd_r;
        div_nxt    = div_r;
        if (psel && !penable)
        begin
            prdata_nxt = 32'h0;
            if (paddr == HC_TXD)
                prdata_nxt[7:0] = txd_r;
            else if (paddr == HC_DIV)
                prdata_nxt[15:0] = div_r;
            else if (paddr == HC_STAT)
            begin
                prdata_nxt[STAT_BUSY]           = (st_r != EH_IDLE);
                prdata_nxt[STAT_NACK]           = nack_r;
                prdata_nxt[STAT_RXD_LSB +: 8]   = sh_r;
            end
        end
        if (done && pwrite && paddr == HC_TXD)
            txd_nxt = pwdata[7:0];
        if (done && pwrite && paddr == HC_DIV)
            div_nxt = pwdata[15:0];
    end

    always_comb
    begin
        st_nxt   = st_r;
        q_nxt    = q_r;
        bit_nxt  = bit_r;
        sh_nxt   = sh_r;
        rd_nxt   = rd_r;
        ackv_nxt = ackv_r;
        nack_nxt = nack_r;
        scl_nxt  = scl_r;
        rel_nxt  = rel_r;
        tick     = (dcnt_r == 16'h0);
        dcnt_nxt = tick ? div_r : dcnt_r - 16'h1;
        if (st_r == EH_IDLE)
        begin
            dcnt_nxt = div_r;
            q_nxt    = 2'h0;
            bit_nxt  = 4'h0;
            if (cmd_go)
            begin
                ackv_nxt = pwdata[CMD_ACK_BIT];
                unique case (op)
                    OP_START: st_nxt = EH_START; // RULE_03 RULE_10
                    OP_WRITE:
                    begin
                        st_nxt = EH_BIT;
                        sh_nxt = txd_r; // RULE_04 RULE_11
                        rd_nxt = 1'b0;
                    end
                    OP_READ:
                    begin
                        st_nxt = EH_BIT;
                        rd_nxt = 1'b1;
                    end
                    OP_STOP:  st_nxt = EH_STOP; // RULE_09
                endcase
            end
        end
        else if (tick)
        begin
            q_nxt = q_r + 2'h1;
            unique case (st_r)
                EH_START:
                    unique case (q_r)
                        2'h0: rel_nxt = 1'b1;
                        2'h1: scl_nxt = 1'b1;
                        2'h2: rel_nxt = 1'b0;
                        2'h3:
                        begin
                            scl_nxt = 1'b0;
                            st_nxt  = EH_IDLE;
                        end
                    endcase
                EH_BIT:
                    unique case (q_r)
                        2'h0:
                            if (bit_r < 4'h8)
                                rel_nxt = rd_r | sh_r[7];
                            else
                                rel_nxt = rd_r ? ackv_r : 1'b1; // RULE_13 RULE_14 RULE_15
                        2'h1: scl_nxt = 1'b1;
                        2'h2:
                            if (bit_r < 4'h8)
                                sh_nxt = {sh_r[6:0], link.sda};
                            else
                                nack_nxt = link.sda;
                        2'h3:
                        begin
                            scl_nxt = 1'b0;
                            bit_nxt = bit_r + 4'h1;
                            if (bit_r == 4'h8)
                            begin
                                st_nxt  = EH_IDLE;
                                rel_nxt = 1'b1;
                            end
                        end
                    endcase
                EH_STOP:
                    unique case (q_r)
                        2'h0: rel_nxt = 1'b0;
                        2'h1: scl_nxt = 1'b1;
                        2'h2:
                        begin
                            rel_nxt = 1'b1;
                            st_nxt  = EH_IDLE;
                        end
                        2'h3: st_nxt = EH_IDLE;
                    endcase
                default: st_nxt = EH_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_r <= 32'h0;
            pready_r <= 1'b0;
            perr_r   <= 1'b0;
            txd_r    <= 8'h00;
            div_r    <= QUARTER;
            st_r     <= EH_IDLE;
            q_r      <= 2'h0;
            bit_r    <= 4'h0;
            dcnt_r   <= 16'h0;
            sh_r     <= 8'h00;
            rd_r     <= 1'b0;
            ackv_r   <= 1'b0;
            nack_r   <= 1'b0;
            scl_r    <= 1'b1;
            rel_r    <= 1'b1;
        end
        else
        begin
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            perr_r   <= perr_nxt;
            txd_r    <= txd_nxt;
            div_r    <= div_nxt;
            st_r     <= st_nxt;
            q_r      <= q_nxt;
            bit_r    <= bit_nxt;
            dcnt_r   <= dcnt_nxt;
            sh_r     <= sh_nxt;
            rd_r     <= rd_nxt;
            ackv_r   <= ackv_nxt;
            nack_r   <= nack_nxt;
            scl_r    <= scl_nxt;
            rel_r    <= rel_nxt;
        end
    end

    assign prdata           = prdata_r;
    assign pready           = pready_r;
    assign pslverr          = perr_r;
    assign link.scl         = scl_r;
    assign link.host_sda_o  = 1'b0;
    assign link.host_sda_oe = ~rel_r;
endmodule : wdi_host
`default_nettype wire

// *** wdi_link_sva.sv ***
// Purpose: Protocol and register checks on the two-wire link
// Assumes: Host quarter period of at least 3 pclk
// Notes:   Instantiated by the bench beside the link
`timescale 1ns/1ns
`default_nettype none
module wdi_link_sva
    import wdi_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        scl,
    input wire logic        sda,
    input wire logic        dev_sda_oe,
    input wire logic        watchdog_enable,
    input wire logic [11:0] timeout_period_ms,
    input wire logic        config_access_open,
    input wire logic [7:0]  watchdog_config
);
    localparam logic [11:0] TMO [8] = '{TMO_MS_0, TMO_MS_1, TMO_MS_2,
        TMO_MS_3, TMO_MS_4, TMO_MS_5, TMO_MS_6, TMO_MS_7};
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_oe_scl_low;
        $changed(dev_sda_oe) |-> !scl && !$past(scl);
    endproperty
    a_oe_scl_low: assert property (p_oe_scl_low)
        else $error("target data moved while clock high");
    property p_oe_holds;
        $rose(dev_sda_oe) |-> dev_sda_oe [*6];
    endproperty
    a_oe_holds: assert property (p_oe_holds)
        else $error("target pulled data low too briefly");
    property p_frame_free;
        scl && $past(scl) && $changed(sda) |-> !dev_sda_oe;
    endproperty
    a_frame_free: assert property (p_frame_free)
        else $error("target held data at start or stop");
    property p_pull_low;
        dev_sda_oe |-> !sda;
    endproperty
    a_pull_low: assert property (p_pull_low)
        else $error("data line high while target pulls");
    property p_enable;
        $stable(watchdog_config) |->
            watchdog_enable == (watchdog_config[7:6] != CFG_EN_OFF);
    endproperty
    a_enable: assert property (p_enable)
        else $error("enable does not follow config field");
    property p_period;
        $stable(watchdog_config) |->
            timeout_period_ms == TMO[watchdog_config[5:3]];
    endproperty
    a_period: assert property (p_period)
        else $error("period does not follow config field");
    property p_locked;
        $changed(watchdog_config) |-> $past(config_access_open);
    endproperty
    a_locked: assert property (p_locked)
        else $error("config changed while locked");
    property p_reset_vals;
        $rose(presetn) |-> !config_access_open && watchdog_enable &&
            watchdog_config == CFG_RST && timeout_period_ms == TMO_MS_1;
    endproperty
    a_reset_vals: assert property (p_reset_vals)
        else $error("wrong values after reset");
endmodule : wdi_link_sva
`default_nettype wire

// *** i2c_slave_register_access_bench.sv ***
// Purpose: Self-checking bench for the two-wire watchdog register port
// Assumes: Target at default address, host quarter of 3 pclk (divider 2)
// Notes:   All link traffic goes through the host's APB registers
`timescale 1ns/1ns
`default_nettype none
module i2c_slave_register_access_bench;
    import wdi_pkg::*;
    logic        pclk;
    logic        presetn = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        wd_en;
    logic [11:0] tmo_ms;
    logic        cfg_open;
    logic [7:0]  wd_cfg;
    logic [31:0] st;
    logic        e;
    int          num_errors = 0;
    int          cmp_count  = 0;
    int          cyc        = 0;
    wdi_if link ();
    wdi_host #(.QUARTER(16'h0002)) wdi_host_inst (.pclk(pclk),
        .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(link.host));
    wdi_dev wdi_dev_inst (.pclk(pclk), .presetn(presetn), .link(link.dev),
        .watchdog_enable(wd_en), .timeout_period_ms(tmo_ms),
        .config_access_open(cfg_open), .watchdog_config(wd_cfg));
    wdi_link_sva wdi_link_sva_inst (.pclk(pclk), .presetn(presetn),
        .scl(link.scl), .sda(link.sda), .dev_sda_oe(link.dev_sda_oe),
        .watchdog_enable(wd_en), .timeout_period_ms(tmo_ms),
        .config_access_open(cfg_open), .watchdog_config(wd_cfg));
    task automatic conclude();
        $display("compares %0d, errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // Ready, data and error are taken at the rising edge ending the access
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        paddr  <= a;
        pwrite <= w;
        pwdata <= d;
        psel   <= 1'b1;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        st = prdata;
        e  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic op(input wdi_op_t o, input logic [7:0] b, input logic ak);
        if (o == OP_WRITE)
            apb(HC_TXD, 1'b1, {24'h0, b});
        apb(HC_CMD, 1'b1, {29'h0, ak, o});
        do
            apb(HC_STAT, 1'b0, 32'h0);
        while (st[STAT_BUSY] !== 1'b0);
    endtask : op
    task automatic wb(input logic [7:0] b, input logic nk);
        op(OP_WRITE, b, 1'b0);
        chk(32'(st[STAT_NACK]), 32'(nk));
    endtask : wb
    task automatic head(input logic [4:0] idx);
        op(OP_START, 8'h00, 1'b0);
        wb({TARGET_ADDR_DEF, 1'b0}, 1'b0);
        wb({3'b000, idx}, 1'b0);
    endtask : head
    task automatic wr_seq(input logic [4:0] idx, input logic [7:0] q[$]);
        head(idx);
        foreach (q[i])
            wb(q[i], 1'b0);
        op(OP_STOP, 8'h00, 1'b0);
    endtask : wr_seq
    task automatic rd_seq(input logic [4:0] idx, input logic [7:0] q[$]);
        head(idx);
        op(OP_START, 8'h00, 1'b0);
        wb({TARGET_ADDR_DEF, 1'b1}, 1'b0);
        foreach (q[i])
        begin
            op(OP_READ, 8'h00, i == q.size() - 1);
            chk(32'(st[15:8]), 32'(q[i]));
        end
        op(OP_STOP, 8'h00, 1'b0);
    endtask : rd_seq
    initial
    begin
        pclk = 1'b0;
        forever
            #25 pclk = ~pclk;
    end
    // Ceiling is several times the expected run length
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            num_errors++;
            conclude();
        end
    end
    initial
    begin
        logic [11:0] tab [8];
        logic [2:0]  cd;
        tab = '{12'h050, 12'h0a0, 12'h140, 12'h1e0, 12'h320, 12'h3e8,
            12'h7d0, 12'hfa0};
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(32'({cfg_open, wd_en, tmo_ms, wd_cfg}),
            32'({2'b01, 12'h0a0, 8'h09}));
        apb(8'h10, 1'b0, 32'h0);
        chk(32'(e), 32'h1);
        chk(st, 32'h0);
        apb(HC_DIV, 1'b0, 32'h0);
        chk(32'(e), 32'h0);
        chk(st, 32'h2);
        wr_seq(IDX_CFG, '{8'h41});
        chk(32'(wd_cfg), 32'h09);
        wr_seq(IDX_KEY, '{KEY_OPEN, 8'h68});
        chk(32'({cfg_open, wd_en, tmo_ms, wd_cfg}),
            32'({2'b10, 12'h3e8, 8'h68}));
        for (int c = 0; c < 8; c++)
        begin
            cd = 3'(c);
            wr_seq(IDX_CFG, '{{cd[1:0], cd, 3'b001}});
            chk(32'(tmo_ms), 32'(tab[cd]));
            chk(32'(wd_en), 32'(cd[1:0] != 2'b01));
        end
        rd_seq(5'h1f, '{8'h00, 8'h00, 8'h00, KEY_OPEN, 8'hf9});
        wr_seq(5'h1f, '{8'h11, 8'h22, 8'h33, 8'h00, 8'h00});
        chk(32'({cfg_open, wd_cfg}), 32'({1'b0, 8'hf9}));
        rd_seq(IDX_CFG, '{8'hf9});
        rd_seq(5'h00, '{8'h00, 8'h00, 8'h00});
        op(OP_START, 8'h00, 1'b0);
        wb(8'h0a, 1'b1);
        op(OP_STOP, 8'h00, 1'b0);
        conclude();
    end
endmodule : i2c_slave_register_access_bench
`default_nettype wire
